// >>> hw/flash_cmd_defines.svh
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH

// Register byte offsets
`define FC_OFS_DIV 9'h100
`define FC_OFS_CFG 9'h101
`define FC_OFS_IDX 9'h102
`define FC_OFS_STAT 9'h106
`define FC_OFS_PROT 9'h108
`define FC_OFS_ARR_HI 9'h10a
`define FC_OFS_ARR_LO 9'h10b
`define FC_OFS_RSV_A 9'h112
`define FC_OFS_RSV_B 9'h113
`define FC_OFS_VER 9'h114

// Field positions
`define FC_DIV_LOADED_BIT 7
`define FC_STAT_COMMAND_COMPLETE_FLAG_BIT 7
`define FC_STAT_ACCESS_ERROR_FLAG_BIT 5
`define FC_STAT_PROTECTION_VIOLATION_FLAG_BIT 4
`define FC_PROT_OPEN_BIT 7
`define FC_VER_PRESENT_BIT 7
`define FC_NUM_WORDS 3'h6

// Reset values
`define FC_DIV_RST 7'h00
`define FC_CFG_RST 8'h00
`define FC_PROT_RST 8'h80
`define FC_CFG_NORMAL_MASK 8'hf0

// Version field codes meaning none
`define FC_VER_NONE_LO 4'h0
`define FC_VER_NONE_HI 4'hf

// Timing
`define FC_SYS_CLK_HZ 25000000
`define FC_FTCLK_TARGET_HZ 1000000

// Command codes
`define FC_CMD_ERS_VFY_ALL 8'h01
`define FC_CMD_ERS_VFY_BLK 8'h02
`define FC_CMD_ERS_VFY_SECT 8'h03
`define FC_CMD_READ_ONCE 8'h04
`define FC_CMD_PROG 8'h06
`define FC_CMD_PROG_ONCE 8'h07
`define FC_CMD_ERS_ALL 8'h08
`define FC_CMD_ERS_BLK 8'h09
`define FC_CMD_ERS_SECT 8'h0a
`define FC_CMD_UNSECURE 8'h0b
`define FC_CMD_BACKDOOR 8'h0c
`define FC_CMD_USER_MARGIN 8'h0d
`define FC_CMD_FIELD_MARGIN 8'h0e
`define FC_CMD_D_VFY_SECT 8'h10
`define FC_CMD_D_PROG 8'h11
`define FC_CMD_D_ERS_SECT 8'h12

`endif

// >>> hw/flash_cmd_pkg.sv
package flash_cmd_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_RUN = 2'b10,
    ST_DONE = 2'b11
  } fsm_t;

  typedef struct packed {
    logic [7:0] code;
    logic [17:0] addr;
    logic [3:0][15:0] data;
  } cmd_t;

  typedef struct packed {
    logic [3:0][15:0] data;
  } result_t;

  typedef struct packed {
    fsm_t fsm;
    logic [6:0] div;
    logic div_loaded;
    logic [7:0] cfg;
    logic [7:0] prot;
    logic [2:0] idx;
    logic [5:0][15:0] arr;
    logic command_complete_flag;
    logic access_error_flag;
    logic protection_violation_flag;
    cmd_t cmd;
    logic cmd_start;
    logic [6:0] tick_cnt;
    logic tick;
    logic [3:0] ver;
    logic ver_ok;
    logic [7:0] rdata;
  } state_t;

endpackage : flash_cmd_pkg

// >>> hw/flash_cmd_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defines.svh"

module flash_cmd_gate
  import flash_cmd_pkg::*;
(
  input wire logic [7:0] code_i,
  input wire logic special_i,
  input wire logic secured_i,
  output logic known_o,
  output logic allowed_o,
  output logic prog_erase_o
);

  always_comb begin
    known_o = 1'b1;
    allowed_o = 1'b0;
    prog_erase_o = 1'b0;
    case (code_i)
      `FC_CMD_ERS_VFY_ALL, `FC_CMD_ERS_VFY_BLK: begin
        allowed_o = 1'b1;
      end
      `FC_CMD_ERS_VFY_SECT, `FC_CMD_READ_ONCE, `FC_CMD_USER_MARGIN,
      `FC_CMD_D_VFY_SECT: begin
        allowed_o = !(secured_i && special_i);
      end
      `FC_CMD_PROG, `FC_CMD_PROG_ONCE, `FC_CMD_ERS_BLK, `FC_CMD_ERS_SECT,
      `FC_CMD_D_PROG, `FC_CMD_D_ERS_SECT: begin
        allowed_o = !(secured_i && special_i);
        prog_erase_o = 1'b1;
      end
      `FC_CMD_ERS_ALL, `FC_CMD_UNSECURE: begin
        allowed_o = special_i;
        prog_erase_o = 1'b1;
      end
      `FC_CMD_BACKDOOR: begin
        allowed_o = !special_i;
      end
      `FC_CMD_FIELD_MARGIN: begin
        allowed_o = special_i && !secured_i;
      end
      default: begin
        known_o = 1'b0;
      end
    endcase
  end

endmodule : flash_cmd_gate
`default_nettype wire

// >>> hw/flash_command_launch.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defines.svh"

// Overview of operation
// - Both factory-test reserved bytes read zero and ignore writes.
// - Mode input low selects normal mode, high selects special mode.
// - Mode steers divider, config, protect writes, scratch writes, commands.
// - Version word keeps a four-bit number in its low bits.
// - Version one is first; all zeros or all ones means no version.
// - Divider write sets the loaded flag; flag zero until written.
// - Program or erase without loaded divider does not run, sets error.
// - While completion is zero, no launch and array writes ignored.
// - Writing one to completion with both error flags clear clears it, captures array, launches command.
// - Completion stays zero until done, then set with results in array.
// - Erase-verify all and erase-verify block allowed in every mode and security state.
// - Ordinary commands allowed everywhere except secured special mode.
// - Erase-all and unsecure allowed only in special mode.
// - Backdoor key check allowed only in normal mode.
// - Field margin allowed only unsecured and in special mode.
// - Command code is first word high byte, parameters follow.
module flash_command_launch
  import flash_cmd_pkg::*;
#(
  parameter int ADDR_W = 9
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic special_mode_select_in_i,
  input wire logic secured_i,
  input wire logic [15:0] info_version_i,
  input wire logic engine_done_i,
  input wire logic engine_viol_i,
  input wire result_t engine_result_i,
  output logic cmd_start_o,
  output cmd_t cmd_o,
  output logic timing_tick_o,
  output logic divider_loaded_o,
  output logic cmd_complete_o,
  output logic scratch_write_en_o,
  output logic [7:0] cfg_o,
  output logic [7:0] prot_o,
  output logic version_present_o
);

  if (ADDR_W < 9) begin : g_addr_check
    $error("ADDR_W must be at least 9");
  end

  // Nominal divider for the flash timing clock at this bus rate
  localparam int DIV_NOMINAL = `FC_SYS_CLK_HZ / `FC_FTCLK_TARGET_HZ - 1;
  localparam logic [6:0] DIV_RECOMMENDED = 7'(DIV_NOMINAL);

  state_t q;
  state_t d;
  logic special_q;
  logic gate_known;
  logic gate_allowed;
  logic gate_prog_erase;
  logic [8:0] addr9;

  assign addr9 = addr_i[8:0];

  flash_cmd_gate u_gate (
    .code_i(q.cmd.code),
    .special_i(special_q),
    .secured_i(secured_i),
    .known_o(gate_known),
    .allowed_o(gate_allowed),
    .prog_erase_o(gate_prog_erase)
  );

  // Upper address bits must be zero for any register hit
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [8:0] ofs);
    logic [ADDR_W-1:0] full;
    full = '0;
    full[8:0] = ofs;
    return a == full;
  endfunction : hit

  // Normal mode may only tighten protection
  function automatic logic [7:0] next_prot(input logic [7:0] cur,
                                           input logic [7:0] wr,
                                           input logic special);
    logic [7:0] res;
    res = wr & 8'h8f;
    if (!special) begin
      res[`FC_PROT_OPEN_BIT] = cur[`FC_PROT_OPEN_BIT] &
                               wr[`FC_PROT_OPEN_BIT];
      if (wr[3:0] < cur[3:0]) begin
        res[3:0] = cur[3:0];
      end
    end
    return res;
  endfunction : next_prot

  function automatic logic ver_valid(input logic [3:0] v);
    return v != `FC_VER_NONE_LO && v != `FC_VER_NONE_HI;
  endfunction : ver_valid

  always_comb begin
    logic [7:0] rd_val;
    logic launch;
    rd_val = 8'h00;
    launch = 1'b0;
    d = q;
    d.cmd_start = 1'b0;
    d.tick = 1'b0;
    d.ver = info_version_i[3:0];
    d.ver_ok = ver_valid(q.ver);

    // Flash timing clock tick from the divider
    if (q.div_loaded) begin
      if (q.tick_cnt >= q.div) begin
        d.tick_cnt = 7'h00;
        d.tick = 1'b1;
      end else begin
        d.tick_cnt = q.tick_cnt + 7'h01;
      end
    end else begin
      d.tick_cnt = 7'h00;
    end

    // Register writes
    if (wr_i) begin
      if (hit(addr_i, `FC_OFS_DIV) && q.command_complete_flag) begin
        if (special_q || !q.div_loaded) begin
          d.div = wdata_i[6:0];
          d.div_loaded = 1'b1;
        end
      end
      if (hit(addr_i, `FC_OFS_CFG) && q.command_complete_flag) begin
        if (special_q) begin
          d.cfg = wdata_i;
        end else begin
          d.cfg = (wdata_i & `FC_CFG_NORMAL_MASK) |
                  (q.cfg & ~`FC_CFG_NORMAL_MASK);
        end
      end
      if (hit(addr_i, `FC_OFS_PROT) && q.command_complete_flag) begin
        d.prot = next_prot(q.prot, wdata_i, special_q);
      end
      if (hit(addr_i, `FC_OFS_IDX)) begin
        d.idx = wdata_i[2:0];
      end
      if (q.command_complete_flag && q.idx < `FC_NUM_WORDS) begin
        if (hit(addr_i, `FC_OFS_ARR_HI)) begin
          d.arr[q.idx][15:8] = wdata_i;
        end
        if (hit(addr_i, `FC_OFS_ARR_LO)) begin
          d.arr[q.idx][7:0] = wdata_i;
        end
      end
      if (hit(addr_i, `FC_OFS_STAT)) begin
        if (wdata_i[`FC_STAT_ACCESS_ERROR_FLAG_BIT]) begin
          d.access_error_flag = 1'b0;
        end
        if (wdata_i[`FC_STAT_PROTECTION_VIOLATION_FLAG_BIT]) begin
          d.protection_violation_flag = 1'b0;
        end
        // Launch refused while busy or an error flag is still set
        if (wdata_i[`FC_STAT_COMMAND_COMPLETE_FLAG_BIT] && q.command_complete_flag &&
            !q.access_error_flag && !q.protection_violation_flag) begin
          launch = 1'b1;
        end
      end
    end

    // Command sequencer
    case (q.fsm)
      ST_IDLE: begin
        if (launch) begin
          d.command_complete_flag = 1'b0;
          d.cmd.code = q.arr[0][15:8];
          d.cmd.addr = {q.arr[0][1:0], q.arr[1]};
          d.cmd.data = {q.arr[5], q.arr[4], q.arr[3], q.arr[2]};
          d.fsm = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (!gate_known || !gate_allowed) begin
          d.access_error_flag = 1'b1;
          d.fsm = ST_DONE;
        end else if (gate_prog_erase && !q.div_loaded) begin
          d.access_error_flag = 1'b1;
          d.fsm = ST_DONE;
        end else begin
          d.cmd_start = 1'b1;
          d.fsm = ST_RUN;
        end
      end
      ST_RUN: begin
        if (engine_done_i) begin
          d.arr[2] = engine_result_i.data[0];
          d.arr[3] = engine_result_i.data[1];
          d.arr[4] = engine_result_i.data[2];
          d.arr[5] = engine_result_i.data[3];
          if (engine_viol_i) begin
            d.protection_violation_flag = 1'b1;
          end
          d.fsm = ST_DONE;
        end
      end
      ST_DONE: begin
        d.command_complete_flag = 1'b1;
        d.fsm = ST_IDLE;
      end
      default: begin
        d.fsm = ST_IDLE;
        d.command_complete_flag = 1'b1;
      end
    endcase

    // Read mux, data valid in the cycle after the strobe
    if (rd_i) begin
      if (hit(addr_i, `FC_OFS_DIV)) begin
        rd_val = {q.div_loaded, q.div};
      end else if (hit(addr_i, `FC_OFS_CFG)) begin
        rd_val = q.cfg;
      end else if (hit(addr_i, `FC_OFS_IDX)) begin
        rd_val = {5'h00, q.idx};
      end else if (hit(addr_i, `FC_OFS_STAT)) begin
        rd_val = 8'h00;
        rd_val[`FC_STAT_COMMAND_COMPLETE_FLAG_BIT] = q.command_complete_flag;
        rd_val[`FC_STAT_ACCESS_ERROR_FLAG_BIT] = q.access_error_flag;
        rd_val[`FC_STAT_PROTECTION_VIOLATION_FLAG_BIT] = q.protection_violation_flag;
      end else if (hit(addr_i, `FC_OFS_PROT)) begin
        rd_val = q.prot;
      end else if (hit(addr_i, `FC_OFS_ARR_HI)) begin
        if (q.idx < `FC_NUM_WORDS) begin
          rd_val = q.arr[q.idx][15:8];
        end
      end else if (hit(addr_i, `FC_OFS_ARR_LO)) begin
        if (q.idx < `FC_NUM_WORDS) begin
          rd_val = q.arr[q.idx][7:0];
        end
      end else if (hit(addr_i, `FC_OFS_RSV_A) ||
                   hit(addr_i, `FC_OFS_RSV_B)) begin
        rd_val = 8'h00;
      end else if (hit(addr_i, `FC_OFS_VER)) begin
        rd_val = {q.ver_ok, 3'h0, q.ver};
      end else begin
        rd_val = 8'h00;
      end
    end
    d.rdata = rd_val;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      q.fsm <= ST_IDLE;
      q.div <= `FC_DIV_RST;
      q.div_loaded <= 1'b0;
      q.cfg <= `FC_CFG_RST;
      q.prot <= `FC_PROT_RST;
      q.idx <= 3'h0;
      q.arr <= '0;
      q.command_complete_flag <= 1'b1;
      q.access_error_flag <= 1'b0;
      q.protection_violation_flag <= 1'b0;
      q.cmd <= '0;
      q.cmd_start <= 1'b0;
      q.tick_cnt <= 7'h00;
      q.tick <= 1'b0;
      q.ver <= 4'h0;
      q.ver_ok <= 1'b0;
      q.rdata <= 8'h00;
      special_q <= 1'b0;
    end else begin
      q <= d;
      special_q <= special_mode_select_in_i;
    end
  end

  assign rdata_o = q.rdata;
  assign cmd_start_o = q.cmd_start;
  assign cmd_o = q.cmd;
  assign timing_tick_o = q.tick;
  assign divider_loaded_o = q.div_loaded;
  assign cmd_complete_o = q.command_complete_flag;
  assign scratch_write_en_o = special_q;
  assign cfg_o = q.cfg;
  assign prot_o = q.prot;
  assign version_present_o = q.ver_ok;

  // Recommended divider kept as an internal signal only, not readable over the bus
  logic [6:0] div_hint;
  assign div_hint = DIV_RECOMMENDED;

endmodule : flash_command_launch
`default_nettype wire

// >>> sim/flash_launch_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module flash_launch_checker
  import flash_cmd_pkg::*;
#(
  parameter int ADDR_W = 9
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic special_mode_select_in_i,
  input wire logic secured_i,
  input wire logic engine_done_i,
  input wire logic cmd_start_o,
  input wire cmd_t cmd_o,
  input wire logic timing_tick_o,
  input wire logic divider_loaded_o,
  input wire logic cmd_complete_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence done_s;
    engine_done_i && !cmd_complete_o && !cmd_start_o;
  endsequence
  sequence finish_s;
    !cmd_complete_o ##1 cmd_complete_o;
  endsequence
  rsv_zero_a: assert property (rd_i && addr_i inside {9'h112, 9'h113} |=> rdata_o == 8'h00) else $error("reserved byte not zero");
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data without strobe");
  launch_cause_a: assert property ($fell(cmd_complete_o) |-> $past(wr_i && addr_i == 9'h106)) else $error("completion fell without launch");
  start_busy_a: assert property (cmd_start_o |-> !cmd_complete_o ##1 !cmd_start_o) else $error("start pulse wrong");
  done_finish_a: assert property (done_s |=> finish_s) else $error("completion not two cycles after done");
  div_set_a: assert property (wr_i && addr_i == 9'h100 && cmd_complete_o |=> divider_loaded_o) else $error("loaded flag not set");
  div_hold_a: assert property (divider_loaded_o |=> divider_loaded_o) else $error("loaded flag dropped");
  tick_gate_a: assert property (!divider_loaded_o |-> !timing_tick_o) else $error("tick without divider");
  pe_nodiv_a: assert property (cmd_start_o && !divider_loaded_o |-> !(cmd_o.code inside {8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h11, 8'h12})) else $error("program or erase without divider");
  backdoor_mode_a: assert property (cmd_start_o && $past(special_mode_select_in_i) |-> cmd_o.code != 8'h0c) else $error("backdoor in special mode");
  margin_sec_a: assert property (cmd_start_o && secured_i && $past(secured_i) |-> cmd_o.code != 8'h0e) else $error("field margin while secured");
endmodule : flash_launch_checker
`default_nettype wire

// >>> sim/flash_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_engine_model
  import flash_cmd_pkg::*;
#(
  parameter int DLY = 6
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic viol_req_i,
  output logic done_o,
  output logic viol_o,
  output result_t res_o
);
  localparam logic [63:0] RES = 64'h0004_0003_0002_5a3c;
  int cnt;
  always @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    if (reset_i) cnt <= 0;
    else if (start_i) cnt <= DLY;
    else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) done_o <= 1'b1;
    end
  end
  assign viol_o = done_o & viol_req_i;
  // Result only valid with done
  assign res_o = done_o ? RES : ~RES;
endmodule : flash_engine_model
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import flash_cmd_pkg::*;
  localparam int ADDR_W = 9;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [8:0] addr_i = 9'h000;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic special_mode_select_in_i = 1'b0;
  logic secured_i = 1'b0;
  logic [15:0] info_version_i = 16'h0003;
  logic engine_done_i, engine_viol_i, cmd_start_o, timing_tick_o;
  logic divider_loaded_o, cmd_complete_o, viol_req = 1'b0;
  result_t engine_result_i;
  cmd_t cmd_o;
  logic scratch_write_en_o, version_present_o;
  logic [7:0] cfg_o, prot_o;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  // {special, secured, accepted, code}
  localparam logic [10:0] ROWS [12] = '{11'h101, 11'h702, 11'h606,
    11'h311, 11'h008, 11'h70b, 11'h40c, 11'h30c, 11'h50e, 11'h00e,
    11'h60e, 11'h005};
  always #20 clk_sys_i = ~clk_sys_i;
  flash_command_launch #(.ADDR_W(ADDR_W)) dut (.clk_sys_i, .reset_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .special_mode_select_in_i,
    .secured_i, .info_version_i, .engine_done_i, .engine_viol_i,
    .engine_result_i, .cmd_start_o, .cmd_o, .timing_tick_o,
    .divider_loaded_o, .cmd_complete_o, .scratch_write_en_o, .cfg_o,
    .prot_o, .version_present_o);
  flash_engine_model eng (.clk_sys_i, .reset_i, .start_i(cmd_start_o),
    .viol_req_i(viol_req), .done_o(engine_done_i), .viol_o(engine_viol_i),
    .res_o(engine_result_i));
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rchk
  task automatic launch(input logic [7:0] code);
    int n;
    n = 0;
    wr(9'h102, 8'h00);
    wr(9'h10a, code);
    wr(9'h10b, 8'h00);
    wr(9'h106, 8'h80);
    @(posedge clk_sys_i);
    #1;
    while (cmd_complete_o !== 1'b1 && n < 50) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk({7'h00, cmd_complete_o}, 8'h01);
  endtask : launch
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    chk(prot_o, 8'h80);
    chk(cfg_o, 8'h00);
    rchk(9'h100, 8'h00);
    launch(8'h06);
    rchk(9'h106, 8'ha0);
    wr(9'h106, 8'h30);
    wr(9'h100, 8'h18);
    rchk(9'h100, 8'h98);
    $display("reset and divider test done");
    foreach (ROWS[i]) begin
      special_mode_select_in_i <= ROWS[i][10];
      secured_i <= ROWS[i][9];
      repeat (4) @(posedge clk_sys_i);
      chk({7'h00, scratch_write_en_o}, {7'h00, ROWS[i][10]});
      launch(ROWS[i][7:0]);
      rchk(9'h106, ROWS[i][8] ? 8'h80 : 8'ha0);
      wr(9'h106, 8'h30);
    end
    $display("command table test done");
    special_mode_select_in_i <= 1'b0;
    secured_i <= 1'b0;
    wr(9'h112, 8'hff);
    wr(9'h113, 8'hff);
    rchk(9'h112, 8'h00);
    rchk(9'h113, 8'h00);
    wr(9'h101, 8'hff);
    #1 chk(cfg_o, 8'hf0);
    wr(9'h108, 8'h05);
    wr(9'h108, 8'h83);
    #1 chk(prot_o, 8'h05);
    $display("reserved test done");
    wr(9'h10a, 8'h01);
    wr(9'h106, 8'h80);
    wr(9'h10a, 8'h77);
    rchk(9'h10a, 8'h01);
    launch(8'h01);
    rchk(9'h106, 8'h80);
    wr(9'h102, 8'h02);
    rchk(9'h10a, 8'h5a);
    rchk(9'h10b, 8'h3c);
    $display("busy and result test done");
    viol_req <= 1'b1;
    launch(8'h02);
    viol_req <= 1'b0;
    rchk(9'h106, 8'h90);
    wr(9'h106, 8'h80);
    rchk(9'h106, 8'h90);
    wr(9'h106, 8'h30);
    $display("violation test done");
    rchk(9'h114, 8'h83);
    chk({7'h00, version_present_o}, 8'h01);
    info_version_i <= 16'hfff1;
    repeat (3) @(posedge clk_sys_i);
    rchk(9'h114, 8'h81);
    info_version_i <= 16'h000f;
    repeat (3) @(posedge clk_sys_i);
    rchk(9'h114, 8'h0f);
    chk({7'h00, version_present_o}, 8'h00);
    $display("version test done");
    end_sim();
  end
endmodule : tb_top
bind flash_command_launch flash_launch_checker #(.ADDR_W(ADDR_W)) chk_u (
  .clk_sys_i, .reset_i, .addr_i, .wr_i, .rd_i, .rdata_o,
  .special_mode_select_in_i, .secured_i, .engine_done_i, .cmd_start_o,
  .cmd_o, .timing_tick_o, .divider_loaded_o, .cmd_complete_o);
`default_nettype wire
